/* File: tac_top.sv */
// Activation, count and module-stop control of the transfer controller.
// What this block does
// - Block count decrements once per transfer; reaching zero ends the count.
// - Six 8-bit read/write enable registers, one bit per interrupt source.
// - Enable registers clear to zero on reset and hardware standby.
// - A source activates the controller only while its enable bit is set.
// - Enable bit clears when transfer ends with select flag set or count done.
// - Enable bit stays set when select flag clear and count not done.
// - Software activation register is 8 bits, zero after reset and standby.
// - Software enable bit accepts a zero write only while the software end interrupt is pending.
// - Vector number is writable only while software enable is zero.
// - Software enable set allows software activation; clear disables it.
// - Software enable clears on select clear and count not done, or 0 write while the end interrupt is pending.
// - Software enable stays set during transfer, on select set or count done.
// - Software vector address is 0x0400 plus vector number shifted left once.
// - Stop bit halts the controller after the current bus cycle.
// - Writing one to the stop bit is refused while the controller operates.
// - Stop register loads 0x3fff on reset and standby, kept in soft standby.
// - Source flag kept with select set, else cleared unless count reached zero.
// - Software transfer end with select set or count done interrupts the CPU.
`timescale 1ns/1ps
module tac_top
  import tac_pkg::*;
(
  // Clock and reset.
  input  wire logic                 clk_i,
  input  wire logic                 rst_n_i,
  // Hardware standby pin.
  input  wire logic                 hw_standby_i,
  // Register port.
  input  wire logic [TAC_AW-1:0]    addr_i,
  input  wire logic [TAC_DW-1:0]    wdata_i,
  input  wire logic                 wr_i,
  input  wire logic                 rd_i,
  output logic      [TAC_DW-1:0]    rdata_o,
  // Interrupt source flags and the transfer bus side.
  input  wire logic [TAC_NSRC-1:0]  src_req_i,
  input  wire logic                 xfer_done_i,
  output logic                      act_valid_o,
  output logic                      act_sw_o,
  output logic      [TAC_IDX_W-1:0] act_src_o,
  output logic      [15:0]          vec_addr_o,
  // Results of a finished transfer.
  output logic                      src_clear_o,
  output logic                      src_cpu_irq_o,
  output logic                      sw_end_irq_o,
  output logic                      stopped_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Standby synchroniser; standby acts like reset on every control register.
  logic stby_s1_q, stby_s2_q, init;

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      {stby_s2_q, stby_s1_q} <= 2'b00;
    else
      {stby_s2_q, stby_s1_q} <= {stby_s1_q, hw_standby_i};
  end

  assign init = !rst_n_i || stby_s2_q;

  ////////////////////////////////////////////////////////////////////////////
  // Decode and state declarations.
  tac_state_t        state_q;
  logic [15:0]       cnt_q;
  logic [7:0]        en_q [TAC_NREG];
  logic [6:0]        vnum_q;
  logic [15:0]       stop_q;
  logic              swen_q, interrupt_select_flag_q, sw_pend_q, sw_irq_q;
  logic              start, start_sw, done, exh, keep, busy;
  logic [TAC_NSRC-1:0] en_flat;

  function automatic logic hit(input logic [TAC_AW-1:0] a,
                               input logic [TAC_AW-1:0] off);
    hit = (a == off);
  endfunction : hit

  function automatic logic [15:0] vaddr(input logic [6:0] num);
    vaddr = TAC_VEC_BASE + {8'h00, num, 1'b0};
  endfunction : vaddr

  genvar g;
  generate
    for (g = 0; g < TAC_NREG; g++)
    begin : g_flat
      assign en_flat[g*8 +: 8] = en_q[g];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Source arbitration.
  tac_arb_if arb_if ();

  assign arb_if.req = src_req_i & en_flat;

  tac_arbiter #(
    .NSRC (TAC_NSRC)
  ) u_arb (
    .arb (arb_if.arb)
  );

  assign start    = (state_q == TAC_IDLE) && !stop_q[TAC_STOP_BIT]
                    && (sw_pend_q || arb_if.gnt_valid);
  assign start_sw = sw_pend_q;
  assign done     = (state_q == TAC_RUN) && xfer_done_i;
  // last transfer when count steps to zero
  assign exh      = (cnt_q == TAC_CNT_LAST);
  assign keep     = interrupt_select_flag_q || exh;
  assign busy     = (state_q == TAC_RUN) || sw_pend_q;

  ////////////////////////////////////////////////////////////////////////////
  // Activation sequence.
  always_ff @(posedge clk_i)
  begin
    if (init)
    begin
      state_q     <= TAC_IDLE;
      act_valid_o <= 1'b0;
      act_sw_o    <= 1'b0;
      act_src_o   <= '0;
      vec_addr_o  <= 16'h0000;
    end
    else
    begin
      case (state_q)
        TAC_IDLE:
        begin
          if (start)
          begin
            state_q     <= TAC_RUN;
            act_valid_o <= 1'b1;
            act_sw_o    <= start_sw;
            act_src_o   <= start_sw ? '0 : arb_if.gnt_idx;
            vec_addr_o  <= start_sw ? vaddr(vnum_q)
                         : vaddr(TAC_SRC_VNUM0 + 7'(arb_if.gnt_idx));
          end
        end
        TAC_RUN:
        begin
          if (xfer_done_i)
          begin
            state_q     <= TAC_IDLE;
            act_valid_o <= 1'b0;
          end
        end
        default:
        begin
          state_q     <= TAC_IDLE;
          act_valid_o <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Block count; the hardware step wins over a software write.
  always_ff @(posedge clk_i)
  begin
    if (init)
      cnt_q <= TAC_CNT_RST;
    else if (done)
      cnt_q <= cnt_q - 16'h0001;
    else if (wr_i && hit(addr_i, TAC_OFF_CNT))
      cnt_q <= wdata_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Enable registers and the end-of-transfer clear.
  always_ff @(posedge clk_i)
  begin
    if (init)
      for (int k = 0; k < TAC_NREG; k++)
        en_q[k] <= TAC_EN_RST;
    else
    begin
      for (int k = 0; k < TAC_NREG; k++)
        if (wr_i && hit(addr_i, TAC_OFF_EN0 + TAC_AW'(k) * TAC_EN_STEP))
          en_q[k] <= wdata_i[7:0];
      // clear on select set or count done
      if (done && !act_sw_o && keep)
        en_q[act_src_o[5:3]][act_src_o[2:0]] <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Results towards the interrupt controller and the CPU.
  always_ff @(posedge clk_i)
  begin
    src_clear_o   <= !init && done && !act_sw_o && !keep;
    src_cpu_irq_o <= !init && done && !act_sw_o && keep;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software activation register.
  always_ff @(posedge clk_i)
  begin
    if (init)
    begin
      swen_q <= TAC_VEC_RST[TAC_SWEN_BIT];
      vnum_q <= TAC_VEC_RST[6:0];
    end
    else
    begin
      if (wr_i && hit(addr_i, TAC_OFF_VEC))
      begin
        if (!swen_q)
          vnum_q <= wdata_i[6:0];
        // only a one sets the enable
        if (wdata_i[TAC_SWEN_BIT])
          swen_q <= 1'b1;
        else if (sw_irq_q)
          swen_q <= 1'b0;
      end
      // cleared by a plain software end
      if (done && act_sw_o && !keep)
        swen_q <= 1'b0;
    end
  end

  // A fresh rising of the enable requests one software activation.
  always_ff @(posedge clk_i)
  begin
    if (init)
      sw_pend_q <= 1'b0;
    else if (wr_i && hit(addr_i, TAC_OFF_VEC) && wdata_i[TAC_SWEN_BIT]
             && !swen_q)
      sw_pend_q <= 1'b1;
    else if (start && start_sw)
      sw_pend_q <= 1'b0;
  end

  // End interrupt of software transfers; the set wins over the clear.
  always_ff @(posedge clk_i)
  begin
    if (init)
      sw_irq_q <= 1'b0;
    else if (done && act_sw_o && keep)
      sw_irq_q <= 1'b1;
    else if (wr_i && hit(addr_i, TAC_OFF_VEC) && !wdata_i[TAC_SWEN_BIT])
      sw_irq_q <= 1'b0;
  end

  assign sw_end_irq_o = sw_irq_q;

  ////////////////////////////////////////////////////////////////////////////
  // Mode flag and module-stop register.
  always_ff @(posedge clk_i)
  begin
    if (init)
      interrupt_select_flag_q <= 1'b0;
    else if (wr_i && hit(addr_i, TAC_OFF_MODE))
      interrupt_select_flag_q <= wdata_i[TAC_INTERRUPT_SELECT_FLAG_BIT];
  end

  always_ff @(posedge clk_i)
  begin
    // loaded with 0x3fff, not touched by soft standby
    if (init)
      stop_q <= TAC_STOP_RST;
    else if (wr_i && hit(addr_i, TAC_OFF_STOP))
    begin
      stop_q <= wdata_i;
      if (busy && wdata_i[TAC_STOP_BIT])
        stop_q[TAC_STOP_BIT] <= stop_q[TAC_STOP_BIT];
    end
  end

  always_ff @(posedge clk_i)
  begin
    // stopped once the bus cycle is over
    stopped_o <= !init && stop_q[TAC_STOP_BIT] && (state_q == TAC_IDLE);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, valid only in the cycle after the read strobe.
  always_ff @(posedge clk_i)
  begin
    if (init || !rd_i)
      rdata_o <= 16'h0000;
    else
    begin
      rdata_o <= 16'h0000;
      if (hit(addr_i, TAC_OFF_CNT))
        rdata_o <= cnt_q;
      for (int k = 0; k < TAC_NREG; k++)
        if (hit(addr_i, TAC_OFF_EN0 + TAC_AW'(k) * TAC_EN_STEP))
          rdata_o <= {8'h00, en_q[k]};
      if (hit(addr_i, TAC_OFF_VEC))
        rdata_o <= {8'h00, swen_q, vnum_q};
      if (hit(addr_i, TAC_OFF_STOP))
        rdata_o <= stop_q;
      if (hit(addr_i, TAC_OFF_MODE))
        rdata_o <= {15'h0000, interrupt_select_flag_q};
      if (hit(addr_i, TAC_OFF_STAT))
      begin
        rdata_o[TAC_ST_BUSY]   <= state_q == TAC_RUN;
        rdata_o[TAC_ST_STOP]   <= stopped_o;
        rdata_o[TAC_ST_SWIRQ]  <= sw_irq_q;
        rdata_o[TAC_ST_SWPEND] <= sw_pend_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  logic [TAC_IDX_W-1:0] src_h;
  logic                 en_h;

  assign src_h = act_src_o;
  assign en_h  = en_flat[src_h];

  cnt_step_a: assert property (@(posedge clk_i) disable iff (init)
    done |=> cnt_q == $past(cnt_q) - 16'h0001)
    else $error("Block count did not step by one.");
  en_init_a: assert property (@(posedge clk_i)
    stby_s2_q && rst_n_i |=> en_flat == '0)
    else $error("Enable bits not cleared by standby.");
  src_gate_a: assert property (@(posedge clk_i) disable iff (init)
    $rose(act_valid_o) && !act_sw_o |-> $past(en_flat[arb_if.gnt_idx]))
    else $error("Disabled source started a transfer.");
  en_clear_a: assert property (@(posedge clk_i) disable iff (init)
    done && !act_sw_o && keep |=> !en_h)
    else $error("Enable bit not cleared at transfer end.");
  en_hold_a: assert property (@(posedge clk_i) disable iff (init)
    done && !act_sw_o && !keep && !wr_i && en_h |=> en_h)
    else $error("Enable bit lost while count runs.");
  swen_zero_a: assert property (@(posedge clk_i) disable iff (init)
    swen_q && !sw_irq_q && !done && wr_i && hit(addr_i, TAC_OFF_VEC)
    |=> swen_q)
    else $error("Zero write cleared the software enable.");
  vnum_lock_a: assert property (@(posedge clk_i) disable iff (init)
    swen_q |=> $stable(vnum_q))
    else $error("Vector number changed while enabled.");
  sw_vec_a: assert property (@(posedge clk_i) disable iff (init)
    $rose(act_valid_o) && act_sw_o
    |-> vec_addr_o == TAC_VEC_BASE + {8'h00, vnum_q, 1'b0})
    else $error("Software vector address wrong.");
  stop_halt_a: assert property (@(posedge clk_i) disable iff (init)
    stop_q[TAC_STOP_BIT] && state_q == TAC_IDLE |=> !act_valid_o)
    else $error("Transfer started in module stop.");
  stop_refuse_a: assert property (@(posedge clk_i) disable iff (init)
    busy && !stop_q[TAC_STOP_BIT] |=> !stop_q[TAC_STOP_BIT])
    else $error("Stop bit set while operating.");
  sw_irq_a: assert property (@(posedge clk_i) disable iff (init)
    done && act_sw_o && keep |=> sw_end_irq_o && swen_q)
    else $error("Software end interrupt missing.");

endmodule : tac_top

/* File: tac_pkg.sv */
// Constants, register map and state type of the transfer activation control.
package tac_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Sizes.
  localparam int TAC_NREG  = 6;
  localparam int TAC_NSRC  = 48;
  localparam int TAC_IDX_W = 6;
  localparam int TAC_AW    = 6;
  localparam int TAC_DW    = 16;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets, byte addresses of aligned words.
  localparam logic [TAC_AW-1:0] TAC_OFF_CNT  = 6'h00;
  localparam logic [TAC_AW-1:0] TAC_OFF_EN0  = 6'h04;
  localparam logic [TAC_AW-1:0] TAC_OFF_VEC  = 6'h1c;
  localparam logic [TAC_AW-1:0] TAC_OFF_STOP = 6'h20;
  localparam logic [TAC_AW-1:0] TAC_OFF_MODE = 6'h24;
  localparam logic [TAC_AW-1:0] TAC_OFF_STAT = 6'h28;
  localparam logic [TAC_AW-1:0] TAC_EN_STEP  = 6'h04;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions.
  localparam int TAC_SWEN_BIT  = 7;
  localparam int TAC_STOP_BIT  = 14;
  localparam int TAC_INTERRUPT_SELECT_FLAG_BIT = 0;
  localparam int TAC_ST_BUSY   = 0;
  localparam int TAC_ST_STOP   = 1;
  localparam int TAC_ST_SWIRQ  = 2;
  localparam int TAC_ST_SWPEND = 3;

  ////////////////////////////////////////////////////////////////////////////
  // Values after reset and vector constants.
  localparam logic [15:0] TAC_CNT_RST   = 16'h0000;
  localparam logic [7:0]  TAC_EN_RST    = 8'h00;
  localparam logic [7:0]  TAC_VEC_RST   = 8'h00;
  localparam logic [15:0] TAC_STOP_RST  = 16'h3fff;
  localparam logic [15:0] TAC_CNT_LAST  = 16'h0001;
  localparam logic [15:0] TAC_VEC_BASE  = 16'h0400;
  localparam logic [6:0]  TAC_SRC_VNUM0 = 7'h10;

  typedef enum logic [0:0] {TAC_IDLE, TAC_RUN} tac_state_t;

endpackage : tac_pkg

/* File: tac_arb_if.sv */
// Request and grant signals between the controller and its source arbiter.
`timescale 1ns/1ps
interface tac_arb_if;
  import tac_pkg::*;
  logic [TAC_NSRC-1:0]  req;
  logic                 gnt_valid;
  logic [TAC_IDX_W-1:0] gnt_idx;
  modport arb (input req, output gnt_valid, output gnt_idx);
  modport ctl (output req, input gnt_valid, input gnt_idx);
endinterface : tac_arb_if

/* File: tac_arbiter.sv */
// Fixed-priority pick among enabled interrupt sources, lowest index first.
`timescale 1ns/1ps
module tac_arbiter
  import tac_pkg::*;
#(
  parameter int NSRC = TAC_NSRC
)
(
  tac_arb_if.arb arb
);

  always_comb
  begin
    arb.gnt_valid = 1'b0;
    arb.gnt_idx   = '0;
    for (int i = NSRC - 1; i >= 0; i--)
    begin
      if (arb.req[i])
      begin
        arb.gnt_valid = 1'b1;
        arb.gnt_idx   = TAC_IDX_W'(i);
      end
    end
  end

endmodule : tac_arbiter

/* File: tac_far_model.sv */
// Far-side model that ends each activation with a transfer-done pulse.
`timescale 1ns/1ps
module tac_far_model
(
  // Clock and reset.
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // Activation seen and answer delay in cycles.
  input  wire logic       act_valid_i,
  input  wire logic [3:0] wait_i,
  // Transfer complete pulse.
  output logic            done_o
);
  logic [3:0] cnt_q;
  logic       seen_q;

  // One pulse per activation, so a slow release cannot end two transfers.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      cnt_q  <= 4'h0;
      seen_q <= 1'b0;
      done_o <= 1'b0;
    end
    else
    begin
      done_o <= 1'b0;
      if (!act_valid_i)
      begin
        seen_q <= 1'b0;
        cnt_q  <= 4'h0;
      end
      else if (!seen_q && cnt_q == wait_i)
      begin
        done_o <= 1'b1;
        seen_q <= 1'b1;
      end
      else if (!seen_q)
        cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule : tac_far_model

/* File: tac_top_test.sv */
// Self-checking bench of the transfer activation control.
`timescale 1ns/1ps
module tac_top_test;
  import tac_pkg::*;
  logic                clk_i = 1'b0;
  logic                rst_n_i = 1'b0;
  logic                hw_standby_i = 1'b0;
  logic [TAC_AW-1:0]   addr_i = '0;
  logic [15:0]         wdata_i = '0;
  logic                wr_i = 1'b0;
  logic                rd_i = 1'b0;
  logic [TAC_NSRC-1:0] src_req_i = '0;
  logic [3:0]          wait_cnt = 4'h2;
  logic [15:0]         rdata_o, vec_addr_o;
  logic [5:0]          act_src_o;
  logic                xfer_done_i, act_valid_o, act_sw_o, src_clear_o;
  logic                src_cpu_irq_o, sw_end_irq_o, stopped_o, clr, irq;
  int                  miscompares = 0;
  int                  checks = 0;

  always #12.5 clk_i = ~clk_i;

  tac_top dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .hw_standby_i(hw_standby_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .src_req_i(src_req_i), .xfer_done_i(xfer_done_i),
    .act_valid_o(act_valid_o), .act_sw_o(act_sw_o), .act_src_o(act_src_o),
    .vec_addr_o(vec_addr_o), .src_clear_o(src_clear_o),
    .src_cpu_irq_o(src_cpu_irq_o), .sw_end_irq_o(sw_end_irq_o),
    .stopped_o(stopped_o));

  tac_far_model u_far (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .act_valid_i(act_valid_o), .wait_i(wait_cnt), .done_o(xfer_done_i));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] e, logic [15:0] g);
    checks++;
    if (g !== e)
    begin
      $display("wrong value %s expected %h seen %h", what, e, g);
      miscompares++;
    end
  endtask : chk

  task automatic wr(input logic [TAC_AW-1:0] a, input logic [15:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1; addr_i <= a; wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr

  task automatic rchk(input logic [TAC_AW-1:0] a, input logic [15:0] e);
    @(posedge clk_i);
    rd_i <= 1'b1; addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk($sformatf("reg %h", a), e, rdata_o);
  endtask : rchk

  task automatic wait_act();
    int n;
    n = 0;
    while (act_valid_o !== 1'b1 && n < 20)
    begin
      @(posedge clk_i); #1; n++;
    end
    chk("act_valid", 16'h0001, {15'h0, act_valid_o});
  endtask : wait_act

  // Returns the one-cycle results that stand as the activation ends.
  task automatic wait_end();
    int n;
    n = 0;
    while (act_valid_o !== 1'b0 && n < 40)
    begin
      @(posedge clk_i); #1; n++;
    end
    chk("act_end", 16'h0000, {15'h0, act_valid_o});
    clr = src_clear_o; irq = src_cpu_irq_o;
    src_req_i <= '0;
  endtask : wait_end

  task automatic no_act();
    logic hit;
    hit = 1'b0;
    repeat (10)
    begin
      @(posedge clk_i); #1 hit |= act_valid_o;
    end
    chk("no activation", 16'h0000, {15'h0, hit});
  endtask : no_act

  task automatic run_src(input logic sel, input logic [15:0] cnt);
    wr(TAC_OFF_MODE, {15'h0, sel}); wr(TAC_OFF_CNT, cnt);
    wr(TAC_OFF_EN0, 16'h0008);
    src_req_i <= 48'h8;
    wait_act();
    chk("act_src", 16'h0003, {10'h0, act_src_o});
    chk("vec_addr", 16'h0426, vec_addr_o);
    wait_end();
  endtask : run_src

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    for (int i = 0; i < TAC_NREG; i++)
      rchk(6'(TAC_OFF_EN0 + TAC_EN_STEP * i), 16'h0000);
    rchk(TAC_OFF_CNT, 16'h0000);
    rchk(TAC_OFF_VEC, 16'h0000);
    rchk(TAC_OFF_STOP, 16'h3fff);
    rchk(6'h2c, 16'h0000);
  endtask : t_reset

  task automatic t_enrw();
    for (int i = 0; i < TAC_NREG; i++)
      wr(6'(TAC_OFF_EN0 + TAC_EN_STEP * i), 16'(8'ha5 ^ 8'(i * 17)));
    for (int i = 0; i < TAC_NREG; i++)
    begin
      rchk(6'(TAC_OFF_EN0 + TAC_EN_STEP * i), 16'(8'ha5 ^ 8'(i * 17)));
      wr(6'(TAC_OFF_EN0 + TAC_EN_STEP * i), 16'h0000);
    end
  endtask : t_enrw

  task automatic t_gate();
    src_req_i <= '1;
    no_act();
    src_req_i <= '0;
  endtask : t_gate

  task automatic t_hold();
    run_src(1'b0, 16'h0005);
    chk("src_clear", 16'h0001, {15'h0, clr});
    chk("cpu_irq", 16'h0000, {15'h0, irq});
    rchk(TAC_OFF_CNT, 16'h0004);
    rchk(TAC_OFF_EN0, 16'h0008);
  endtask : t_hold

  task automatic t_interrupt_select_flag();
    run_src(1'b1, 16'h0005);
    chk("src_clear", 16'h0000, {15'h0, clr});
    chk("cpu_irq", 16'h0001, {15'h0, irq});
    rchk(TAC_OFF_EN0, 16'h0000);
  endtask : t_interrupt_select_flag

  task automatic t_last();
    run_src(1'b0, 16'h0001);
    chk("cpu_irq", 16'h0001, {15'h0, irq});
    rchk(TAC_OFF_CNT, 16'h0000);
    rchk(TAC_OFF_EN0, 16'h0000);
  endtask : t_last

  task automatic t_sw();
    wait_cnt <= 4'hc;
    wr(TAC_OFF_MODE, 16'h0000); wr(TAC_OFF_CNT, 16'h0005);
    wr(TAC_OFF_VEC, 16'h0010);
    wr(TAC_OFF_VEC, 16'h0090);
    wait_act();
    chk("act_sw", 16'h0001, {15'h0, act_sw_o});
    chk("sw vec_addr", 16'h0420, vec_addr_o);
    wr(TAC_OFF_VEC, 16'h0025);
    rchk(TAC_OFF_VEC, 16'h0090);
    wait_end();
    rchk(TAC_OFF_VEC, 16'h0010);
    chk("sw_end_irq", 16'h0000, {15'h0, sw_end_irq_o});
  endtask : t_sw

  task automatic t_sw_end();
    wr(TAC_OFF_MODE, 16'h0001);
    wr(TAC_OFF_VEC, 16'h0090);
    wait_act();
    wait_end();
    chk("sw_end_irq", 16'h0001, {15'h0, sw_end_irq_o});
    rchk(TAC_OFF_STAT, 16'h0004);
    wr(TAC_OFF_VEC, 16'h0085);
    rchk(TAC_OFF_VEC, 16'h0090);
    wr(TAC_OFF_VEC, 16'h0010);
    rchk(TAC_OFF_VEC, 16'h0010);
    chk("sw_end_irq", 16'h0000, {15'h0, sw_end_irq_o});
  endtask : t_sw_end

  task automatic t_stop();
    wr(TAC_OFF_MODE, 16'h0000); wr(TAC_OFF_CNT, 16'h0005);
    wr(TAC_OFF_EN0, 16'h0001);
    src_req_i <= 48'h1;
    wait_act();
    wr(TAC_OFF_STOP, 16'h7fff);
    rchk(TAC_OFF_STOP, 16'h3fff);
    wait_end();
    wr(TAC_OFF_STOP, 16'h7fff);
    rchk(TAC_OFF_STOP, 16'h7fff);
    chk("stopped", 16'h0001, {15'h0, stopped_o});
    rchk(TAC_OFF_STAT, 16'h0002);
    src_req_i <= 48'h1;
    no_act();
    wr(TAC_OFF_STOP, 16'h3fff);
    wait_act();
    chk("stopped", 16'h0000, {15'h0, stopped_o});
    wait_end();
  endtask : t_stop

  task automatic t_standby();
    wr(TAC_OFF_EN0 + TAC_EN_STEP, 16'h00ff);
    wr(TAC_OFF_STOP, 16'h7fff);
    hw_standby_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    hw_standby_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    rchk(TAC_OFF_EN0 + TAC_EN_STEP, 16'h0000);
    rchk(TAC_OFF_EN0, 16'h0000);
    rchk(TAC_OFF_STOP, 16'h3fff);
    rchk(TAC_OFF_VEC, 16'h0000);
  endtask : t_standby

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test

  initial
  begin
    #(25 * 6000);
    miscompares++;
    end_of_test();
  end

  initial
  begin
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_reset(); t_enrw(); t_gate(); t_hold(); t_interrupt_select_flag(); t_last();
    t_sw(); t_sw_end(); t_stop(); t_standby();
    end_of_test();
  end
endmodule : tac_top_test
